/* File: vda_pkg.sv */
package vda_pkg;
   localparam int DW = 16;
   localparam int AW = 12;
   // interface memory locations
   localparam logic [AW-1:0] ADDR_VOLUME = 12'h001;
   localparam logic [AW-1:0] ADDR_OPERATING_CONFIG_CODE = 12'h010;
   localparam logic [AW-1:0] ADDR_SPKPH = 12'h013;
   localparam logic [AW-1:0] ADDR_CTRL = 12'h400;
   localparam logic [AW-1:0] ADDR_RSTAT = 12'h419;
   localparam logic [AW-1:0] ADDR_LSTAT = 12'h41a;
   localparam logic [AW-1:0] ADDR_SCALE = 12'h990;
   localparam logic [AW-1:0] ADDR_ECHO = 12'ha5c;
   localparam logic [AW-1:0] ADDR_NOISE = 12'hbb3;
   // control word bits
   localparam int CTRL_SQUELCH_BIT = 2;
   localparam int CTRL_HANDSET_BIT = 5;
   localparam int CTRL_AGC_BIT = 6;
   localparam int CTRL_HDGC_BIT = 7;
   localparam int RSTAT_ONHOOK_BIT = 7;
   localparam int VOLUME_POS = 6;
   // speakerphone register bits
   localparam int SPK_UP_BIT = 6;
   localparam int SPK_DOWN_BIT = 5;
   localparam int SPK_SELECT_BIT = 4;
   localparam int SPK_LMUTE_BIT = 3;
   localparam int SPK_MMUTE_BIT = 2;
   localparam int SPK_MICLVL_POS = 0;
   // local status bits
   localparam int LSTAT_RING_BIT = 0;
   localparam int LSTAT_RINGBACK_BIT = 1;
   localparam int LSTAT_STEP_POS = 4;
   // values
   localparam logic [DW-1:0] SCALE_DEFAULT = 16'hf000;
   localparam logic [DW-1:0] ECHO_ENABLE_WORD = 16'h8004;
   localparam logic [DW-1:0] NOISE_SUGGESTED = 16'h0005;
   localparam logic [7:0] OPERATING_CONFIG_CODE_SPEAKERPHONE = 8'hac;
   localparam logic [7:0] OPERATING_CONFIG_CODE_RESET = 8'h00;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] SPKPH_RESET = 8'h10;
   localparam logic [1:0] VOLUME_RESET = 2'h2;
   localparam int STEP_DB = 2;
   localparam int STEP_LIMIT_DB = 10;
   localparam logic signed [3:0] STEP_MAX = 4'(STEP_LIMIT_DB / STEP_DB);
   typedef logic signed [3:0] vda_step_t;
endpackage

/* File: vda_noise_if.sv */
interface vda_noise_if;
   logic [15:0] level;
   logic step;
   logic [15:0] noise;
   modport gen(input level, input step, output noise);
   modport user(output level, output step, input noise);
endinterface

/* File: vda_noise_gen.sv */
module vda_noise_gen
   import vda_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic arst_n_in,
   vda_noise_if.gen nif
);
   logic [15:0] lfsr_reg;
   logic [7:0] lvl;
   logic signed [12:0] prod;

   always_comb begin
      lvl = (|nif.level[15:8]) ? 8'hff : nif.level[7:0];
      prod = $signed(lfsr_reg[3:0]) * $signed({1'b0, lvl});
   end

   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         lfsr_reg <= 16'hace1;
      end else if (nif.step) begin
         lfsr_reg <= {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]};
      end
   end

   // amplitude scales with the level word up to 8'hff, then holds; zero level gives silence
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         nif.noise <= 16'h0000;
      end else if (nif.step) begin
         nif.noise <= (nif.level == 16'h0000) ? 16'h0000 : {{3{prod[12]}}, prod};
      end
   end
endmodule

/* File: vda_ctrl.sv */
// Function
// - handset bit routes voice via handset pins, else mic and speaker pins
// - mic AGC runs only while the AGC control bit is set
// - half-duplex gain control adjusts gains while set; audio stays full duplex
// - handset volume from speaker scale word; default restored on renegotiation or retrain
// - two-bit volume field ignored while handset mode is selected
// - local squelch bit is mirrored as remote on-hook status at the far modem
// - squelch suppresses all outgoing audio
// - ring only when squelch set and remote on-hook clear
// - ringback only when squelch clear and remote on-hook set
// - non-zero noise word injects outgoing noise, louder for larger values up to 8'hff
// - select 1 runs full duplex; 0 freezes gains, no correlator, echo bypass
// - each volume up or down step moves speaker gain by 2 dB, holding at the 10 dB limit
module vda_ctrl
   import vda_pkg::*;
#(
   parameter int DATA_W = DW
) (
   input wire logic clk_sys_in,
   input wire logic arst_n_in,
   input wire logic [AW-1:0] reg_addr_in,
   input wire logic [DW-1:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [DW-1:0] reg_rdata_out,
   input wire logic remote_squelch_in,
   input wire logic rate_renegotiation_request_in,
   input wire logic retrain_request_in,
   input wire logic sample_valid_in,
   input wire logic [DATA_W-1:0] voice_mic_in,
   input wire logic [DATA_W-1:0] handset_audio_in,
   input wire logic [DATA_W-1:0] line_rx_in,
   output logic [DATA_W-1:0] line_tx_out,
   output logic [DATA_W-1:0] speaker_out,
   output logic [DATA_W-1:0] handset_audio_out,
   output logic squelch_tx_out,
   output logic ring_out,
   output logic ringback_out,
   output logic agc_enable_out,
   output logic hdgc_enable_out,
   output logic gain_freeze_out,
   output logic xcorr_disable_out,
   output logic aec_bypass_out,
   output logic echo_cancel_enable_out,
   output logic [DW-1:0] speaker_scale_out,
   output logic [1:0] voice_mic_level_out,
   output vda_step_t speaker_step_out,
   output logic speakerphone_mode_out
);
   // datapath and saturation are sized from the package width; noise is fixed at 16 bits
   if (DATA_W != DW) begin : g_width_check
      $error("vda_ctrl: DATA_W must equal package DW");
   end

   logic [7:0] ctrl_reg;
   logic [7:0] spkph_reg;
   logic [7:0] operating_config_code_reg;
   logic [1:0] volume_reg;
   logic [DW-1:0] scale_reg;
   logic [DW-1:0] echo_reg;
   logic [DW-1:0] noise_reg;
   logic remote_onhook_reg;
   vda_step_t step_reg;
   logic wr_spkph;
   logic step_up;
   logic step_down;
   logic squelch;
   logic handset;
   logic [DW-1:0] mic_sel;
   logic [DW-1:0] tx_next;
   logic [DW-1:0] spk_next;

   vda_noise_if nif ();

   vda_noise_gen u_noise (
      .clk_sys_in(clk_sys_in),
      .arst_n_in(arst_n_in),
      .nif(nif)
   );

   function automatic logic hit(input logic [AW-1:0] a, input logic [AW-1:0] loc);
      return a == loc;
   endfunction

   function automatic logic [DW-1:0] sat_add(input logic [DW-1:0] a, input logic [DW-1:0] b);
      logic [DW:0] s;
      s = {a[DW-1], a} + {b[DW-1], b};
      if (s[DW] != s[DW-1]) begin
         return s[DW] ? {1'b1, {(DW-1){1'b0}}} : {1'b0, {(DW-1){1'b1}}};
      end
      return s[DW-1:0];
   endfunction

   assign squelch = ctrl_reg[CTRL_SQUELCH_BIT];
   assign handset = ctrl_reg[CTRL_HANDSET_BIT];
   assign wr_spkph = reg_wr_in && hit(reg_addr_in, ADDR_SPKPH);
   assign step_up = wr_spkph && reg_wdata_in[SPK_UP_BIT];
   assign step_down = wr_spkph && reg_wdata_in[SPK_DOWN_BIT];
   assign nif.level = noise_reg;
   assign nif.step = sample_valid_in;

   // register writes
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         ctrl_reg <= CTRL_RESET;
         operating_config_code_reg <= OPERATING_CONFIG_CODE_RESET;
         volume_reg <= VOLUME_RESET;
         echo_reg <= 16'h0000;
         noise_reg <= 16'h0000;
         spkph_reg <= SPKPH_RESET;
      end else if (reg_wr_in) begin
         if (hit(reg_addr_in, ADDR_CTRL)) ctrl_reg <= reg_wdata_in[7:0];
         if (hit(reg_addr_in, ADDR_OPERATING_CONFIG_CODE)) operating_config_code_reg <= reg_wdata_in[7:0];
         if (hit(reg_addr_in, ADDR_VOLUME)) volume_reg <= reg_wdata_in[VOLUME_POS +: 2];
         if (hit(reg_addr_in, ADDR_ECHO)) echo_reg <= reg_wdata_in;
         if (hit(reg_addr_in, ADDR_NOISE)) noise_reg <= reg_wdata_in;
         // step bits act as pulses and are not stored
         if (wr_spkph) spkph_reg <= {2'b00, reg_wdata_in[5:0] & 6'h1f};
      end
   end

   // speaker scale: renegotiation or retrain wins over a host write in the same cycle
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         scale_reg <= SCALE_DEFAULT;
      end else if (rate_renegotiation_request_in || retrain_request_in) begin
         scale_reg <= SCALE_DEFAULT;
      end else if (reg_wr_in && hit(reg_addr_in, ADDR_SCALE)) begin
         scale_reg <= reg_wdata_in;
      end
   end

   // volume trim in fixed steps, saturating at the table limits
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         step_reg <= 4'sh0;
      end else if (step_up && !step_down && step_reg < STEP_MAX) begin
         step_reg <= step_reg + 4'sh1;
      end else if (step_down && !step_up && step_reg > -STEP_MAX) begin
         step_reg <= step_reg - 4'sh1;
      end
   end

   // received status of the far modem's squelch
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         remote_onhook_reg <= 1'b0;
      end else begin
         remote_onhook_reg <= remote_squelch_in;
      end
   end

   // read port, data valid only in the cycle after the strobe
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         reg_rdata_out <= 16'h0000;
      end else if (reg_rd_in) begin
         unique case (1'b1)
            hit(reg_addr_in, ADDR_CTRL): reg_rdata_out <= {8'h00, ctrl_reg};
            hit(reg_addr_in, ADDR_OPERATING_CONFIG_CODE): reg_rdata_out <= {8'h00, operating_config_code_reg};
            hit(reg_addr_in, ADDR_VOLUME): reg_rdata_out <= 16'(volume_reg) << VOLUME_POS;
            hit(reg_addr_in, ADDR_SPKPH): reg_rdata_out <= {8'h00, spkph_reg};
            hit(reg_addr_in, ADDR_RSTAT): reg_rdata_out <= 16'(remote_onhook_reg) << RSTAT_ONHOOK_BIT;
            hit(reg_addr_in, ADDR_LSTAT): reg_rdata_out <= (16'(ring_out) << LSTAT_RING_BIT)
               | (16'(ringback_out) << LSTAT_RINGBACK_BIT) | (16'(unsigned'(step_reg)) << LSTAT_STEP_POS);
            hit(reg_addr_in, ADDR_SCALE): reg_rdata_out <= scale_reg;
            hit(reg_addr_in, ADDR_ECHO): reg_rdata_out <= echo_reg;
            hit(reg_addr_in, ADDR_NOISE): reg_rdata_out <= noise_reg;
            default: reg_rdata_out <= 16'h0000;
         endcase
      end else begin
         reg_rdata_out <= 16'h0000;
      end
   end

   // tone enables recomputed every cycle from the two squelch states
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         ring_out <= 1'b0;
         ringback_out <= 1'b0;
         squelch_tx_out <= 1'b0;
      end else begin
         ring_out <= squelch && !remote_onhook_reg;
         ringback_out <= !squelch && remote_onhook_reg;
         squelch_tx_out <= squelch;
      end
   end

   // gain and canceller controls
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         agc_enable_out <= 1'b0;
         hdgc_enable_out <= 1'b0;
         gain_freeze_out <= 1'b1;
         xcorr_disable_out <= 1'b1;
         aec_bypass_out <= 1'b1;
         echo_cancel_enable_out <= 1'b0;
         speakerphone_mode_out <= 1'b0;
         voice_mic_level_out <= 2'b00;
         speaker_scale_out <= SCALE_DEFAULT;
         speaker_step_out <= 4'sh0;
      end else begin
         agc_enable_out <= ctrl_reg[CTRL_AGC_BIT] && spkph_reg[SPK_SELECT_BIT];
         hdgc_enable_out <= ctrl_reg[CTRL_HDGC_BIT];
         gain_freeze_out <= !spkph_reg[SPK_SELECT_BIT];
         xcorr_disable_out <= !spkph_reg[SPK_SELECT_BIT];
         aec_bypass_out <= !spkph_reg[SPK_SELECT_BIT];
         // the canceller is only meaningful in handset use
         echo_cancel_enable_out <= handset && (echo_reg == ECHO_ENABLE_WORD);
         speakerphone_mode_out <= (operating_config_code_reg == OPERATING_CONFIG_CODE_SPEAKERPHONE) && spkph_reg[SPK_SELECT_BIT];
         voice_mic_level_out <= spkph_reg[SPK_MICLVL_POS +: 2];
         speaker_scale_out <= scale_reg;
         speaker_step_out <= step_reg;
      end
   end

   // audio datapath
   always_comb begin
      mic_sel = handset ? handset_audio_in : voice_mic_in;
      if (spkph_reg[SPK_MMUTE_BIT]) mic_sel = 16'h0000;
      tx_next = squelch ? 16'h0000 : sat_add(mic_sel, nif.noise);
      if (spkph_reg[SPK_LMUTE_BIT]) begin
         spk_next = 16'h0000;
      end else begin
         unique case (volume_reg)
            2'b00: spk_next = 16'h0000;
            2'b01: spk_next = line_rx_in;
            2'b10: spk_next = DW'($signed(line_rx_in) >>> 1);
            2'b11: spk_next = DW'($signed(line_rx_in) >>> 2);
         endcase
      end
   end

   // handset output bypasses the volume field; level set via the scale word
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         line_tx_out <= 16'h0000;
         speaker_out <= 16'h0000;
         handset_audio_out <= 16'h0000;
      end else if (sample_valid_in) begin
         line_tx_out <= tx_next;
         speaker_out <= handset ? 16'h0000 : spk_next;
         handset_audio_out <= handset && !spkph_reg[SPK_LMUTE_BIT] ? line_rx_in : 16'h0000;
      end
   end

   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!arst_n_in);

   sequence s_sample_handset;
      sample_valid_in && handset;
   endsequence

   property p_route_handset;
      s_sample_handset |=> speaker_out == 16'h0000;
   endproperty
   a_route_handset: assert property (p_route_handset) else $error("speaker driven in handset mode");

   property p_agc;
      agc_enable_out |-> $past(ctrl_reg[CTRL_AGC_BIT]);
   endproperty
   a_agc: assert property (p_agc) else $error("agc on without control bit");

   property p_hdgc;
      ##1 hdgc_enable_out == $past(ctrl_reg[CTRL_HDGC_BIT]);
   endproperty
   a_hdgc: assert property (p_hdgc) else $error("half-duplex gain control mismatch");

   property p_scale_restore;
      (rate_renegotiation_request_in || retrain_request_in) |=> ##1 speaker_scale_out == SCALE_DEFAULT;
   endproperty
   a_scale_restore: assert property (p_scale_restore) else $error("scale not restored");

   property p_volume_ignored;
      s_sample_handset |=> handset_audio_out == 16'h0000 || handset_audio_out == $past(line_rx_in);
   endproperty
   a_volume_ignored: assert property (p_volume_ignored) else $error("volume field altered handset audio");

   property p_squelch_tx;
      (sample_valid_in && squelch) |=> line_tx_out == 16'h0000;
   endproperty
   a_squelch_tx: assert property (p_squelch_tx) else $error("audio sent while squelched");

   sequence s_ring_cond;
      squelch && !remote_onhook_reg;
   endsequence

   property p_ring;
      ##1 ring_out == $past(squelch && !remote_onhook_reg);
   endproperty
   a_ring: assert property (p_ring) else $error("ring state wrong");

   property p_ring_hold;
      s_ring_cond ##1 s_ring_cond |-> ring_out && !ringback_out;
   endproperty
   a_ring_hold: assert property (p_ring_hold) else $error("ring not held");

   property p_ringback;
      ##1 ringback_out == $past(!squelch && remote_onhook_reg);
   endproperty
   a_ringback: assert property (p_ringback) else $error("ringback state wrong");

   property p_freeze;
      !spkph_reg[SPK_SELECT_BIT] |=> gain_freeze_out && xcorr_disable_out && aec_bypass_out && !agc_enable_out;
   endproperty
   a_freeze: assert property (p_freeze) else $error("handset mode gains not frozen");

   property p_step_up;
      (step_up && !step_down && step_reg < STEP_MAX) |=> step_reg == $past(step_reg) + 4'sh1;
   endproperty
   a_step_up: assert property (p_step_up) else $error("volume up step missing");
endmodule

/* File: vda_remote_model.sv */
module vda_remote_model (
   input wire logic clk_sys_in,
   input wire logic arst_n_in,
   input wire logic local_squelch_in,
   input wire logic remote_hook_in,
   input wire logic slow_in,
   output logic remote_squelch_out,
   output logic peer_onhook_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] hook_pipe_reg;

   // far modem shows our squelch as its own on-hook status
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in)
         peer_onhook_out <= 1'b0;
      else
         peer_onhook_out <= local_squelch_in;
   end

   // slow answer delays the far user's hook change by four cycles
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in)
         hook_pipe_reg <= 4'h0;
      else
         hook_pipe_reg <= {hook_pipe_reg[2:0], remote_hook_in};
   end

   assign remote_squelch_out = slow_in ? hook_pipe_reg[3] : hook_pipe_reg[0];
endmodule

/* File: vda_ctrl_bench.sv */
module vda_ctrl_bench
   import vda_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 1'b0;
   logic arst_n = 1'b0;
   logic [AW-1:0] reg_addr = '0;
   logic [DW-1:0] reg_wdata = '0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic reneg = 1'b0;
   logic retrain = 1'b0;
   logic sample_valid = 1'b0;
   logic remote_hook = 1'b0;
   logic remote_slow = 1'b0;
   logic [DW-1:0] mic = '0;
   logic [DW-1:0] hs_in = '0;
   logic [DW-1:0] rx = '0;
   logic [DW-1:0] reg_rdata, line_tx, spk, hs_out, scale;
   logic remote_squelch, peer_onhook, sq_tx, ring, ringback, agc, hdgc;
   logic freeze, xcorr, bypass, echo_en, sp_mode, exp_ring, exp_rb;
   logic [1:0] mic_lvl;
   vda_step_t step;
   int miscompares = 0;
   int checks_done = 0;
   int cycles = 0;
   int diffs;

   always #2 clk_sys = ~clk_sys;

   vda_ctrl i_dut (
      .clk_sys_in(clk_sys),
      .arst_n_in(arst_n),
      .reg_addr_in(reg_addr),
      .reg_wdata_in(reg_wdata),
      .reg_wr_in(reg_wr),
      .reg_rd_in(reg_rd),
      .reg_rdata_out(reg_rdata),
      .remote_squelch_in(remote_squelch),
      .rate_renegotiation_request_in(reneg),
      .retrain_request_in(retrain),
      .sample_valid_in(sample_valid),
      .voice_mic_in(mic),
      .handset_audio_in(hs_in),
      .line_rx_in(rx),
      .line_tx_out(line_tx),
      .speaker_out(spk),
      .handset_audio_out(hs_out),
      .squelch_tx_out(sq_tx),
      .ring_out(ring),
      .ringback_out(ringback),
      .agc_enable_out(agc),
      .hdgc_enable_out(hdgc),
      .gain_freeze_out(freeze),
      .xcorr_disable_out(xcorr),
      .aec_bypass_out(bypass),
      .echo_cancel_enable_out(echo_en),
      .speaker_scale_out(scale),
      .voice_mic_level_out(mic_lvl),
      .speaker_step_out(step),
      .speakerphone_mode_out(sp_mode)
   );

   vda_remote_model i_remote (
      .clk_sys_in(clk_sys),
      .arst_n_in(arst_n),
      .local_squelch_in(sq_tx),
      .remote_hook_in(remote_hook),
      .slow_in(remote_slow),
      .remote_squelch_out(remote_squelch),
      .peer_onhook_out(peer_onhook)
   );

   task automatic chk(input string name, input logic [DW-1:0] exp, input logic [DW-1:0] got);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic chk_bit(input string name, input logic exp, input logic got);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %b seen %b", name, exp, got);
      end
   endtask

   task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input string name, input logic [AW-1:0] a, input logic [DW-1:0] exp);
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1;
      chk(name, exp, reg_rdata);
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask

   // noise lags one sample, so callers take two samples before judging
   task automatic smp(input logic [DW-1:0] m, input logic [DW-1:0] h, input logic [DW-1:0] r);
      @(posedge clk_sys);
      sample_valid <= 1'b1;
      mic <= m;
      hs_in <= h;
      rx <= r;
      @(posedge clk_sys);
      sample_valid <= 1'b0;
      #1;
   endtask

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 5000) begin
         miscompares++;
         give_verdict();
      end
   end

   initial begin
      repeat (12) @(posedge clk_sys);
      #1;
      chk_bit("freeze in reset", 1'b1, freeze);
      chk_bit("bypass in reset", 1'b1, bypass);
      chk_bit("ring in reset", 1'b0, ring);
      chk("scale in reset", SCALE_DEFAULT, scale);
      @(posedge clk_sys);
      arst_n <= 1'b1;
      rd("ctrl", ADDR_CTRL, 16'h0000);
      rd("volume", ADDR_VOLUME, 16'h0080);
      rd("speakerphone", ADDR_SPKPH, 16'h0010);
      rd("config", ADDR_OPERATING_CONFIG_CODE, 16'h0000);
      rd("scale", ADDR_SCALE, SCALE_DEFAULT);
      rd("noise", ADDR_NOISE, 16'h0000);
      wr(12'h7f0, 16'hffff);
      rd("unmapped", 12'h7f0, 16'h0000);
      // mic/speaker setup first, then handset; volume field swept in each
      for (int hs = 0; hs < 2; hs++) begin
         wr(ADDR_CTRL, 16'(hs ? 8'ha0 : 8'hc0));
         settle(2);
         chk_bit("agc", hs == 0, agc);
         chk_bit("hdgc", 1'b1, hdgc);
         for (int v = 0; v < 4; v++) begin
            wr(ADDR_VOLUME, 16'(v << VOLUME_POS));
            settle(2);
            smp(16'h0123, 16'h0345, 16'h0400);
            smp(16'h0123, 16'h0345, 16'h0400);
            chk("line tx", hs ? 16'h0345 : 16'h0123, line_tx);
            chk("speaker", (hs || v == 0) ? 16'h0000 : 16'h0800 >> v, spk);
            chk("handset out", hs ? 16'h0400 : 16'h0000, hs_out);
         end
      end
      wr(ADDR_ECHO, ECHO_ENABLE_WORD);
      settle(2);
      chk_bit("echo enable", 1'b1, echo_en);
      rd("echo word", ADDR_ECHO, ECHO_ENABLE_WORD);
      wr(ADDR_CTRL, 16'h0000);
      settle(2);
      chk_bit("echo off headset", 1'b0, echo_en);
      chk_bit("agc headset", 1'b0, agc);
      chk_bit("hdgc headset", 1'b0, hdgc);
      wr(ADDR_ECHO, 16'h0000);
      // each local squelch and remote hook combination must move the tones
      for (int k = 0; k < 4; k++) begin
         remote_slow <= k[0];
         // squelch bit follows k[1], remote hook follows k[0], slow remote answer on odd k
         wr(ADDR_CTRL, 16'(k[1] ? 8'h04 : 8'h00));
         @(posedge clk_sys);
         remote_hook <= k[0];
         settle(8);
         exp_ring = k[1] && !k[0];
         exp_rb = !k[1] && k[0];
         chk_bit("squelch out", k[1], sq_tx);
         chk_bit("peer on-hook", k[1], peer_onhook);
         chk_bit("ring", exp_ring, ring);
         chk_bit("ringback", exp_rb, ringback);
         rd("remote status", ADDR_RSTAT, {8'h00, k[0], 7'h00});
         rd("local status", ADDR_LSTAT, {14'h0, exp_rb, exp_ring});
      end
      @(posedge clk_sys);
      remote_hook <= 1'b0;
      wr(ADDR_NOISE, NOISE_SUGGESTED);
      smp(16'h0100, 16'h0000, 16'h0000);
      smp(16'h0100, 16'h0000, 16'h0000);
      chk("squelched tx", 16'h0000, line_tx);
      wr(ADDR_CTRL, 16'h0000);
      settle(2);
      diffs = 0;
      for (int i = 0; i < 8; i++) begin
         smp(16'h0100, 16'h0000, 16'h0000);
         if (line_tx !== 16'h0100)
            diffs++;
      end
      chk_bit("noise present", 1'b1, diffs > 0);
      rd("noise word", ADDR_NOISE, NOISE_SUGGESTED);
      rd("remote off-hook", ADDR_RSTAT, 16'h0000);
      wr(ADDR_NOISE, 16'h0000);
      smp(16'h0100, 16'h0000, 16'h0000);
      smp(16'h0100, 16'h0000, 16'h0000);
      chk("quiet tx", 16'h0100, line_tx);
      wr(ADDR_OPERATING_CONFIG_CODE, 16'(OPERATING_CONFIG_CODE_SPEAKERPHONE));
      wr(ADDR_SPKPH, 16'h001f);
      wr(ADDR_SPKPH, 16'h0013);
      settle(2);
      chk_bit("speakerphone", 1'b1, sp_mode);
      chk("mic level", 16'h0003, 16'(mic_lvl));
      chk_bit("freeze off", 1'b0, freeze);
      wr(ADDR_CTRL, 16'h0040);
      wr(ADDR_SPKPH, 16'h0003);
      settle(2);
      chk_bit("freeze", 1'b1, freeze);
      chk_bit("xcorr off", 1'b1, xcorr);
      chk_bit("echo bypass", 1'b1, bypass);
      chk_bit("agc frozen", 1'b0, agc);
      chk_bit("speakerphone off", 1'b0, sp_mode);
      for (int i = 0; i < 6; i++)
         wr(ADDR_SPKPH, 16'h0053);
      settle(2);
      chk("step top", 16'h0005, {12'h000, step});
      rd("status step top", ADDR_LSTAT, 16'h0050);
      for (int i = 0; i < 11; i++)
         wr(ADDR_SPKPH, 16'h0033);
      wr(ADDR_SPKPH, 16'h0073);
      settle(2);
      chk("step bottom", 16'h000b, {12'h000, step});
      rd("step bits read", ADDR_SPKPH, 16'h0013);
      for (int j = 0; j < 2; j++) begin
         wr(ADDR_SCALE, 16'hfc00);
         settle(2);
         chk("scale word", 16'hfc00, scale);
         @(posedge clk_sys);
         retrain <= (j == 0);
         reneg <= (j == 1);
         @(posedge clk_sys);
         retrain <= 1'b0;
         reneg <= 1'b0;
         settle(2);
         chk("scale restored", SCALE_DEFAULT, scale);
      end
      give_verdict();
   end
endmodule
